// ---- logic/bssp_defs.vh ----
`ifndef BSSP_DEFS_VH
`define BSSP_DEFS_VH
`define BSSP_MODE_TX8 3'h0
`define BSSP_MODE_TX4 3'h2
`define BSSP_MODE_TRX8 3'h4
`define BSSP_MODE_RX8 3'h5
`define BSSP_MODE_RX4 3'h6
`define BSSP_CLK_DIV13 3'h0
`define BSSP_CLK_DIV8 3'h1
`define BSSP_CLK_DIV6 3'h2
`define BSSP_CLK_DIV5 3'h3
`define BSSP_CLK_EXT 3'h7
`define BSSP_SHIFT_DIV13 13
`define BSSP_SHIFT_DIV8 8
`define BSSP_SHIFT_DIV6 6
`define BSSP_SHIFT_DIV5 5
`define BSSP_BUF_WORDS 8
`define BSSP_FIFO_DEPTH 4
`endif

// ---- logic/bssp_fifo.v ----
`timescale 1ns/1ps
module bssp_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = 4,
	parameter AW = 2
) (
	input wire clk_sys_i,
	input wire rstn_i,
	input wire flush_i,
	input wire in_valid_i,
	output wire in_ready_o,
	input wire [WIDTH-1:0] in_data_i,
	output wire out_valid_o,
	input wire out_ready_i,
	output wire [WIDTH-1:0] out_data_o
);
	localparam [AW:0] FULL = DEPTH;
	reg [WIDTH-1:0] mem_q [0:DEPTH-1];
	reg [AW-1:0] wr_q;
	reg [AW-1:0] rd_q;
	reg [AW:0] cnt_q;
	wire push;
	wire pop;
	assign in_ready_o = (cnt_q != FULL);
	assign out_valid_o = (cnt_q != {(AW+1){1'b0}});
	assign out_data_o = mem_q[rd_q];
	assign push = in_valid_i & in_ready_o;
	assign pop = out_valid_o & out_ready_i;
	always @(posedge clk_sys_i) begin
		if (push) begin
			mem_q[wr_q] <= in_data_i;
		end
	end
	always @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			wr_q <= {AW{1'b0}};
			rd_q <= {AW{1'b0}};
			cnt_q <= {(AW+1){1'b0}};
		end else if (flush_i) begin
			wr_q <= {AW{1'b0}};
			rd_q <= {AW{1'b0}};
			cnt_q <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				wr_q <= wr_q + {{(AW-1){1'b0}}, 1'b1};
			end
			if (pop) begin
				rd_q <= rd_q + {{(AW-1){1'b0}}, 1'b1};
			end
			if (push && !pop) begin
				cnt_q <= cnt_q + {{AW{1'b0}}, 1'b1};
			end else if (pop && !push) begin
				cnt_q <= cnt_q - {{AW{1'b0}}, 1'b1};
			end
		end
	end
endmodule

// ---- logic/bssp_core.v ----
`timescale 1ns/1ps
// What this block does
// - Clock select picks one of four internal rates or external pin clock.
// - With internal clock the serial clock pin idles high at start.
// - Internal rates are clock divided by 2^13 or slow tick/2, 2^8, 2^6, 2^5.
// - Internal clock halts while software buffer accesses fall behind.
// - Transmit on falling pin edge, receive sampled on rising pin edge.
// - Four-bit mode shifts low nibble; received upper nibble stored as zero.
// - Every word travels least significant bit first.
// - Up to eight counted words move, then the done interrupt rises.
// - A three-bit mode field selects transmit, receive or both.
// - Run starts first word; next word loads after its last bit; empty irq at end.
// - Internal transmit waits for new data; one buffer write releases it.
// - Any buffer write or read, even unused entries, cancels a wait.
// - After the last word the data pin holds its final bit.
// - Clearing run finishes the current word, stores that word, clears flag.
// - External transmit not stopped in time sends dummy data then ends.
// - Received words go to successive buffer entries; full irq at count.
// - Internal receive stops the clock while earlier words stay unread.
// - External receive with unread data discards the word and stops.
// - Abort ends the transfer at once and drops partial received data.
// - Changing the mode discards the buffer contents unless a buffer write or received word lands in that cycle.
// - Transmit/receive mode waits for reads and writes; one write releases.
// - Abort bit clears itself once the abort has completed.
// - Mode codes 000, 010, 100, 101, 110 as listed.
// - Word count field holds words minus one, from base entry upward.
// - Wait field stretches each internal 8-bit receive word to 1, 2, 4 or 8 word times.
`include "bssp_defs.vh"
module bssp_core #(
	parameter DIV_SLOW_SHIFT = `BSSP_SHIFT_DIV13
) (
	input wire clk_sys_i,
	input wire rstn_i,
	input wire transfer_run_bit_i,
	input wire transfer_abort_bit_i,
	input wire [2:0] transfer_mode_field_i,
	input wire [2:0] clock_select_i,
	input wire divider_clock_select_i,
	input wire slow_tick_i,
	input wire [2:0] word_count_i,
	input wire [1:0] wait_field_i,
	input wire buf_wr_i,
	input wire [2:0] buf_addr_i,
	input wire [7:0] buf_wdata_i,
	input wire buf_rd_i,
	output reg [7:0] buf_rdata_o,
	input wire sck_in_i,
	output wire sck_out_o,
	output wire sck_oe_o,
	input wire si_i,
	output wire so_o,
	output wire transfer_active_flag_o,
	output wire shift_active_flag_o,
	output wire transfer_abort_bit_o,
	output reg transfer_done_irq_o,
	output wire rx_valid_o,
	input wire rx_ready_i,
	output wire [7:0] rx_data_o
);
	localparam ST_IDLE = 2'h0;
	localparam ST_SHIFT = 2'h1;
	localparam ST_WAIT = 2'h2;
	localparam ST_GAP = 2'h3;
	reg [7:0] data_buffer_ram [0:`BSSP_BUF_WORDS-1];
	reg [1:0] st_q;
	reg [12:0] div_q;
	reg [7:0] sh_q;
	reg [2:0] bit_q;
	reg [2:0] word_q;
	reg [2:0] mode_q;
	reg sck_q;
	reg so_q;
	reg act_q;
	reg stop_q;
	reg abort_q;
	reg pend_q;
	reg [6:0] gap_q;
	reg sck_s1_q;
	reg sck_s2_q;
	reg sck_s3_q;
	reg si_s1_q;
	reg si_s2_q;
	reg ff_push_q;
	reg [7:0] ff_data_q;
	reg tick_sel;
	integer j;
	wire ext;
	wire four;
	wire tx;
	wire rx;
	wire tick;
	wire fall;
	wire rise;
	wire touch;
	wire [2:0] last_bit;
	wire ff_ready;
	wire [7:0] rx_word;
	assign ext = (clock_select_i == `BSSP_CLK_EXT);
	assign four = (mode_q == `BSSP_MODE_TX4) || (mode_q == `BSSP_MODE_RX4);
	assign tx = (mode_q == `BSSP_MODE_TX8) || (mode_q == `BSSP_MODE_TX4) ||
		(mode_q == `BSSP_MODE_TRX8);
	assign rx = (mode_q == `BSSP_MODE_TRX8) || (mode_q == `BSSP_MODE_RX8) ||
		(mode_q == `BSSP_MODE_RX4);
	assign last_bit = four ? 3'h3 : 3'h7;
	assign touch = buf_wr_i | buf_rd_i;
	// The divider produces a half-period tick so the pin toggles each tick.
	always @* begin
		case (clock_select_i)
		`BSSP_CLK_DIV8: tick_sel = (div_q[6:0] == 7'h7F);
		`BSSP_CLK_DIV6: tick_sel = (div_q[4:0] == 5'h1F);
		`BSSP_CLK_DIV5: tick_sel = (div_q[3:0] == 4'hF);
		`BSSP_CLK_DIV13: tick_sel = divider_clock_select_i ? slow_tick_i :
			(&div_q[DIV_SLOW_SHIFT-2:0]);
		default: tick_sel = 1'b0;
		endcase
	end
	assign tick = tick_sel;
	// Pin edges are derived only after two sync stages.
	assign fall = ext ? (sck_s3_q & ~sck_s2_q) : (tick & sck_q);
	assign rise = ext ? (~sck_s3_q & sck_s2_q) : (tick & ~sck_q);
	assign sck_out_o = sck_q;
	assign sck_oe_o = ~ext;
	assign so_o = so_q;
	assign transfer_active_flag_o = act_q;
	assign shift_active_flag_o = (st_q == ST_SHIFT);
	assign transfer_abort_bit_o = abort_q;
	assign rx_word = four ? {4'h0, si_s2_q, sh_q[7:5]} :
		{si_s2_q, sh_q[7:1]};
	always @(posedge clk_sys_i) begin
		if (buf_wr_i) begin
			data_buffer_ram[buf_addr_i] <= buf_wdata_i;
		end else if (st_q == ST_SHIFT && rise && bit_q == last_bit && rx &&
			!pend_q) begin
			data_buffer_ram[word_q] <= rx_word;
		end else if (transfer_mode_field_i != mode_q) begin
			// Old words are meaningless in a new mode, so they are wiped.
			for (j = 0; j < `BSSP_BUF_WORDS; j = j + 1) begin
				data_buffer_ram[j] <= 8'h00;
			end
		end
		if (buf_rd_i) begin
			buf_rdata_o <= data_buffer_ram[buf_addr_i];
		end
	end
	always @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			sck_s1_q <= 1'b1;
			sck_s2_q <= 1'b1;
			sck_s3_q <= 1'b1;
			si_s1_q <= 1'b0;
			si_s2_q <= 1'b0;
			div_q <= 13'h0000;
		end else begin
			sck_s1_q <= sck_in_i;
			sck_s2_q <= sck_s1_q;
			sck_s3_q <= sck_s2_q;
			si_s1_q <= si_i;
			si_s2_q <= si_s1_q;
			div_q <= div_q + 13'h0001;
		end
	end
	always @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			st_q <= ST_IDLE;
			sh_q <= 8'h00;
			bit_q <= 3'h0;
			word_q <= 3'h0;
			mode_q <= `BSSP_MODE_TX8;
			sck_q <= 1'b1;
			so_q <= 1'b1;
			act_q <= 1'b0;
			stop_q <= 1'b0;
			abort_q <= 1'b0;
			pend_q <= 1'b0;
			gap_q <= 7'h00;
			transfer_done_irq_o <= 1'b0;
			ff_push_q <= 1'b0;
			ff_data_q <= 8'h00;
		end else begin
			transfer_done_irq_o <= 1'b0;
			ff_push_q <= 1'b0;
			if (transfer_abort_bit_i) begin
				abort_q <= 1'b1;
			end
			if (transfer_mode_field_i != mode_q) begin
				mode_q <= transfer_mode_field_i;
			end
			if (!transfer_run_bit_i && act_q) begin
				stop_q <= 1'b1;
			end
			if (touch) begin
				pend_q <= 1'b0;
			end
			if (abort_q) begin
				st_q <= ST_IDLE;
				act_q <= 1'b0;
				sck_q <= 1'b1;
				stop_q <= 1'b0;
				abort_q <= 1'b0;
			end else begin
				case (st_q)
				ST_IDLE: begin
					sck_q <= 1'b1;
					if (transfer_run_bit_i) begin
						act_q <= 1'b1;
						st_q <= ST_SHIFT;
						word_q <= 3'h0;
						bit_q <= 3'h0;
						stop_q <= 1'b0;
						pend_q <= 1'b0;
						sh_q <= data_buffer_ram[0];
					end
				end
				ST_SHIFT: begin
					if (!ext && tick) begin
						sck_q <= ~sck_q;
					end
					if (fall && tx) begin
						so_q <= sh_q[0];
					end
					if (rise) begin
						sh_q <= {si_s2_q, sh_q[7:1]};
						bit_q <= bit_q + 3'h1;
						if (bit_q == last_bit) begin
							bit_q <= 3'h0;
							if (rx && !pend_q) begin
								ff_push_q <= ff_ready;
								ff_data_q <= rx_word;
							end
							if (stop_q) begin
								st_q <= ST_IDLE;
								act_q <= 1'b0;
							end else if (ext && pend_q) begin
								st_q <= ST_IDLE;
								act_q <= 1'b0;
							end else begin
								if (word_q == word_count_i) begin
									word_q <= 3'h0;
									transfer_done_irq_o <= 1'b1;
									pend_q <= 1'b1;
									sh_q <= data_buffer_ram[0];
								end else begin
									word_q <= word_q + 3'h1;
									sh_q <= data_buffer_ram[word_q + 3'h1];
								end
								gap_q <= 7'h00;
								if (!ext) begin
									st_q <= ST_GAP;
								end
							end
						end
					end
				end
				ST_GAP: begin
					// Wait field stretches the word time in internal 8-bit receive modes.
					if (tick) begin
						gap_q <= gap_q + 7'h01;
					end
					if (!(mode_q == `BSSP_MODE_RX8 ||
						mode_q == `BSSP_MODE_TRX8) || wait_field_i == 2'h0 ||
						gap_q >= ((7'h10 << wait_field_i) - 7'h10)) begin
						st_q <= ST_WAIT;
					end
				end
				ST_WAIT: begin
					// Hold the clock high until software catches up.
					// No bit is moving here, so a stop ends the transfer now.
					if (stop_q || !transfer_run_bit_i) begin
						st_q <= ST_IDLE;
						act_q <= 1'b0;
					end else if (!pend_q || touch) begin
						st_q <= ST_SHIFT;
						pend_q <= 1'b0;
					end
				end
				default: st_q <= ST_IDLE;
				endcase
			end
		end
	end
	// Received words also stream out; a full queue simply drops the copy.
	bssp_fifo #(
		.WIDTH(8),
		.DEPTH(`BSSP_FIFO_DEPTH),
		.AW(2)
	) u_fifo (
		.clk_sys_i(clk_sys_i),
		.rstn_i(rstn_i),
		.flush_i(abort_q),
		.in_valid_i(ff_push_q),
		.in_ready_o(ff_ready),
		.in_data_i(ff_data_q),
		.out_valid_o(rx_valid_o),
		.out_ready_i(rx_ready_i),
		.out_data_o(rx_data_o)
	);
endmodule

// ---- verification/bssp_core_properties.sv ----
`timescale 1ns/1ps
module bssp_core_properties (
	input wire clk_sys_i,
	input wire rstn_i,
	input wire transfer_run_bit_i,
	input wire transfer_abort_bit_i,
	input wire [2:0] clock_select_i,
	input wire sck_out_o,
	input wire sck_oe_o,
	input wire so_o,
	input wire transfer_active_flag_o,
	input wire transfer_abort_bit_o,
	input wire transfer_done_irq_o
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!rstn_i);
	sequence s_launch;
		$rose(transfer_run_bit_i) && !transfer_active_flag_o &&
			!transfer_abort_bit_i;
	endsequence
	sequence s_active;
		##[1:2] transfer_active_flag_o;
	endsequence
	property p_start;
		s_launch |-> s_active;
	endproperty
	a_start: assert property (p_start) else $error("run ignored");
	property p_sck_idle;
		$rose(transfer_active_flag_o) && sck_oe_o |-> sck_out_o;
	endproperty
	a_sck_idle: assert property (p_sck_idle) else $error("sck low");
	property p_ext_oe;
		clock_select_i == 3'h7 && $past(clock_select_i) == 3'h7 |-> !sck_oe_o;
	endproperty
	a_ext_oe: assert property (p_ext_oe) else $error("sck driven");
	property p_abort;
		transfer_abort_bit_i |-> ##[1:2] !transfer_active_flag_o;
	endproperty
	a_abort: assert property (p_abort) else $error("abort slow");
	property p_abort_clr;
		transfer_abort_bit_o && !transfer_abort_bit_i |=> !transfer_abort_bit_o;
	endproperty
	a_abort_clr: assert property (p_abort_clr) else $error("abort stuck");
	property p_irq;
		transfer_done_irq_o |=> !transfer_done_irq_o;
	endproperty
	a_irq: assert property (p_irq) else $error("irq too long");
	property p_so_hold;
		sck_oe_o && sck_out_o && $past(sck_out_o) && transfer_active_flag_o &&
			$past(transfer_active_flag_o) |-> $stable(so_o);
	endproperty
	a_so_hold: assert property (p_so_hold) else $error("so moved");
	property p_stop;
		$fell(transfer_run_bit_i) && sck_oe_o |->
			##[1:1000] !transfer_active_flag_o;
	endproperty
	a_stop: assert property (p_stop) else $error("stop slow");
endmodule
bind bssp_core bssp_core_properties u_props (.clk_sys_i(clk_sys_i),
	.rstn_i(rstn_i), .transfer_run_bit_i(transfer_run_bit_i),
	.transfer_abort_bit_i(transfer_abort_bit_i),
	.clock_select_i(clock_select_i), .sck_out_o(sck_out_o),
	.sck_oe_o(sck_oe_o), .so_o(so_o),
	.transfer_active_flag_o(transfer_active_flag_o),
	.transfer_abort_bit_o(transfer_abort_bit_o),
	.transfer_done_irq_o(transfer_done_irq_o));

// ---- verification/bssp_peer.sv ----
`timescale 1ns/1ps
module bssp_peer (
	input wire sck_i,
	input wire so_i,
	input wire clr_i,
	input wire [63:0] pat_i,
	output reg si_o,
	output reg [63:0] cap_o,
	output reg [6:0] cnt_o
);
	always @(posedge sck_i or posedge clr_i) begin
		if (clr_i) begin
			cnt_o <= 7'h00;
			cap_o <= 64'h0;
		end else begin
			cap_o[cnt_o[5:0]] <= so_i;
			cnt_o <= cnt_o + 7'h01;
		end
	end
	// Idle shows the wrong level so a bit taken early cannot pass.
	always @(negedge sck_i or posedge clr_i) begin
		if (clr_i)
			si_o <= ~pat_i[0];
		else
			si_o <= pat_i[cnt_o[5:0]];
	end
endmodule

// ---- verification/testbench.sv ----
`timescale 1ns/1ps
module testbench;
	typedef struct packed {
		logic [2:0] m, c;
		logic d;
		logic [2:0] n;
		logic [31:0] v;
		logic [8:0] per;
	} bssp_row_t;
	logic clk_sys_i = 1'b0, rstn_i = 1'b0, run = 1'b0, abort = 1'b0;
	logic [2:0] mode = 3'h0, csel = 3'h0, cnt = 3'h0, addr = 3'h0;
	logic dcs = 1'b0, tick = 1'b0, wr = 1'b0, rd = 1'b0, sck_ext = 1'b1;
	logic rx_ready = 1'b1, clr = 1'b1, prev_sck = 1'b1;
	logic [1:0] waitf = 2'h0, tc = 2'h0;
	logic [7:0] wdata = 8'h00, rxd, rdata;
	logic [63:0] pat = 64'h0, ex, msk;
	wire sck, si, so, sck_o, oe, act, irq, rxv, abort_o, shf;
	wire [63:0] cap;
	wire [6:0] pcnt;
	int fail_count = 0, comparisons = 0, irqs = 0, per = 0, cyc = 0, i;
	logic [7:0] rxq [$];
	bssp_row_t rows [9];
	assign sck = oe ? sck_o : sck_ext;
	bssp_core #(.DIV_SLOW_SHIFT(4)) u_dut (.clk_sys_i(clk_sys_i),
		.rstn_i(rstn_i), .transfer_run_bit_i(run),
		.transfer_abort_bit_i(abort), .transfer_mode_field_i(mode),
		.clock_select_i(csel), .divider_clock_select_i(dcs),
		.slow_tick_i(tick), .word_count_i(cnt), .wait_field_i(waitf),
		.buf_wr_i(wr), .buf_addr_i(addr), .buf_wdata_i(wdata),
		.buf_rd_i(rd), .buf_rdata_o(rdata), .sck_in_i(sck),
		.sck_out_o(sck_o), .sck_oe_o(oe), .si_i(si), .so_o(so),
		.transfer_active_flag_o(act), .shift_active_flag_o(shf),
		.transfer_abort_bit_o(abort_o), .transfer_done_irq_o(irq),
		.rx_valid_o(rxv), .rx_ready_i(rx_ready), .rx_data_o(rxd));
	bssp_peer u_peer (.sck_i(sck), .so_i(so), .clr_i(clr), .pat_i(pat),
		.si_o(si), .cap_o(cap), .cnt_o(pcnt));
	initial begin
		forever #5 clk_sys_i = ~clk_sys_i;
	end
	// Reading each word as it lands keeps an internal receive from waiting.
	always @(posedge clk_sys_i) begin
		tc <= tc + 2'h1;
		tick <= &tc;
		prev_sck <= sck_o;
		cyc <= (oe && prev_sck && !sck_o) ? 1 : cyc + 1;
		if (oe && prev_sck && !sck_o)
			per <= cyc;
		if (irq)
			irqs <= irqs + 1;
		rd <= rxv && rx_ready;
		if (rxv && rx_ready)
			rxq.push_back(rxd);
	end
	task tk(input int k);
		repeat (k) @(posedge clk_sys_i);
	endtask
	task chk(input string nm, input logic [63:0] e, input logic [63:0] g);
		comparisons++;
		if (g !== e) begin
			fail_count++;
			$display("CHECK FAILED %s exp %h got %h", nm, e, g);
		end
	endtask
	task go(input logic [2:0] m, c, n, input logic d);
		@(posedge clk_sys_i);
		mode <= m;
		csel <= c;
		cnt <= n;
		dcs <= d;
		clr <= 1'b1;
		rx_ready <= m != 3'h6;
		rxq.delete();
		@(posedge clk_sys_i);
		clr <= 1'b0;
	endtask
	task wait_idle;
		int t;
		for (t = 0; t < 3000 && act !== 1'b0; t++)
			@(posedge clk_sys_i);
	endtask
	task run_row(input bssp_row_t r);
		int w, k, t, i0;
		w = (r.m == 3'h2 || r.m == 3'h6) ? 4 : 8;
		for (k = 0; k < 64; k++) begin
			ex[k] = k < w * (r.n + 1) ? r.v[k / w * 8 + k % w] : 1'b0;
			msk[k] = k < w * (r.n + 1);
		end
		pat = ~ex;
		go(r.m, r.c, r.n, r.d);
		for (k = 0; k <= r.n; k++) begin
			wr <= 1'b1;
			addr <= k[2:0];
			wdata <= r.v[k * 8 +: 8];
			@(posedge clk_sys_i);
		end
		wr <= 1'b0;
		run <= 1'b1;
		i0 = irqs;
		if (r.c == 3'h7)
			repeat (w) begin
				tk(8);
				sck_ext <= 1'b0;
				tk(8);
				sck_ext <= 1'b1;
			end
		for (t = 0; t < 8000 && irqs == i0; t++)
			@(posedge clk_sys_i);
		run <= 1'b0;
		if (r.c == 3'h7) begin
			abort <= 1'b1;
			@(posedge clk_sys_i);
			abort <= 1'b0;
		end
		wait_idle;
		tk(20);
		rx_ready <= 1'b1;
		tk(20);
		chk("done irq", 1, irqs - i0);
		if (r.m != 3'h5 && r.m != 3'h6)
			chk("tx bits", ex, cap & msk);
		if (r.m[2]) begin
			chk("rx count", r.n + 1, rxq.size());
			for (k = 0; k <= r.n && k < rxq.size(); k++)
				chk("rx word", {w == 8 ? ~r.v[k * 8 + 4 +: 4] : 4'h0,
					~r.v[k * 8 +: 4]}, rxq[k]);
		end
		if (r.per != 9'h0)
			chk("bit period", r.per, per);
	endtask
	task close_out;
		$display("checks %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		repeat (60000) @(posedge clk_sys_i);
		fail_count++;
		close_out();
	end
	initial begin
		rows[0] = {3'h0, 3'h3, 1'h0, 3'h2, 32'h813CA5, 9'h020};
		rows[1] = {3'h2, 3'h2, 1'h0, 3'h1, 32'h09F6, 9'h040};
		rows[2] = {3'h5, 3'h1, 1'h0, 3'h1, 32'hE45A, 9'h100};
		rows[3] = {3'h6, 3'h3, 1'h0, 3'h0, 32'hB7, 9'h020};
		rows[4] = {3'h4, 3'h3, 1'h0, 3'h0, 32'h96, 9'h020};
		rows[5] = {3'h0, 3'h7, 1'h0, 3'h0, 32'hC3, 9'h000};
		rows[6] = {3'h5, 3'h7, 1'h0, 3'h0, 32'h2D, 9'h000};
		rows[7] = {3'h0, 3'h0, 1'h1, 3'h0, 32'h6E, 9'h008};
		rows[8] = {3'h5, 3'h0, 1'h0, 3'h0, 32'h71, 9'h010};
		tk(16);
		rstn_i <= 1'b1;
		tk(2);
		chk("idle pins", 64'h18, {sck_o, so, act, irq, abort_o});
		for (i = 0; i < 9; i++) begin
			run_row(rows[i]);
			$display("row %0d done", i);
		end
		go(3'h5, 3'h3, 3'h0, 1'b0);
		run <= 1'b1;
		tk(100);
		abort <= 1'b1;
		@(posedge clk_sys_i);
		abort <= 1'b0;
		run <= 1'b0;
		tk(3);
		chk("abort flag", 0, act);
		tk(60);
		chk("abort word", 0, rxq.size());
		chk("abort bit", 0, abort_o);
		$display("abort test done");
		go(3'h5, 3'h3, 3'h0, 1'b0);
		run <= 1'b1;
		tk(100);
		run <= 1'b0;
		wait_idle;
		tk(20);
		chk("partial word", 1, rxq.size());
		chk("stop flag", 0, act);
		$display("stop test done");
		close_out();
	end
endmodule
